// *** verilog/adcc_pkg.sv ***
// Functional notes
// [R1] A channel/gain write during a conversion applies only after that conversion completes.
// [R2] A reference-select write during a conversion applies only after that conversion completes.
// [R3] The first conversion after a reference change lasts 25 ADC clock cycles.
// [R4] Reference: x00 supply, x01 external pin, 010 internal 1.1V, 110 internal 2.56V.
// [R5] The five-bit channel field picks the input pair and, when differential, the gain.
// [R6] The left-align bit reformats the result readout at once, even mid-conversion.
// [R7] Result high byte at 0x79, low at 0x78, aligned per left-align bit.
// [R8] Reading the low byte freezes the result until the high byte is read.
// [R9] Prescale codes 100..111 divide the I/O clock by 16, 32, 64, 128.
// [R10] The channel is captured within one ADC clock of writing the start bit.
// [R11] Free running restarts at each completion with the channel latched at restart.
// [R12] Halting in idle or noise-reduction sleep starts a conversion when armed.
// [R13] An early wake-up does not stop the conversion or its completion request.
// [R14] Other sleep modes never disable the converter; only software clears the enable.
// [R15] A single-ended input above the reference yields full scale 0x3ff.
// [R16] Software should discard the first result after a reference switch.
// [R17] Completion sets the done flag; a request needs its enable and the global enable.
// [R18] A completion while the result is frozen discards the new result.
package adcc_pkg;
	// Register addresses
	localparam logic [7:0] ADDR_RES_LOW  = 8'h78;
	localparam logic [7:0] ADDR_RES_HIGH = 8'h79;
	localparam logic [7:0] ADDR_CTRL     = 8'h7a;
	localparam logic [7:0] ADDR_MISC     = 8'h7b;
	localparam logic [7:0] ADDR_SEL      = 8'h7c;
	// Reset values
	localparam logic [7:0] SEL_RST  = 8'h00;
	localparam logic [7:0] CTRL_RST = 8'h00;
	// Field positions in input_and_reference_select
	localparam int SEL_REF_HI = 7;
	localparam int SEL_REF_LO = 6;
	localparam int SEL_LEFT   = 5;
	// Field positions in converter_control_status
	localparam int CTRL_EN    = 7;
	localparam int CTRL_START = 6;
	localparam int CTRL_FREE  = 5;
	localparam int CTRL_DONE  = 4;
	localparam int CTRL_IE    = 3;
	// Field position in analog_misc_control
	localparam int MISC_EXTREF = 0;
	// Conversion lengths in ADC clock cycles
	localparam logic [4:0] LONG_CONV_CYCLES = 5'd25;
	localparam logic [4:0] CONV_CYCLES_DEF  = 5'd13;
	// Full-scale code
	localparam logic [9:0] FULL_SCALE = 10'h3ff;
	// Decoded reference sources
	typedef enum logic [1:0] {
		ADCC_REF_SUPPLY = 2'b00,
		ADCC_REF_EXTPIN = 2'b01,
		ADCC_REF_INT_1V1 = 2'b10,
		ADCC_REF_INT_2V56 = 2'b11
	} adcc_ref_e;
	// Converter states
	typedef enum logic [0:0] {
		ADCC_IDLE = 1'b0,
		ADCC_CONV = 1'b1
	} adcc_state_e;
endpackage

// *** verilog/adcc_presc_if.sv ***
`timescale 1ns/100ps
// Prescaler control and the ADC clock tick it returns
interface adcc_presc_if;
	logic [2:0] sel;
	logic       run;
	logic       tick;
	modport ctrl (output sel, output run, input tick);
	modport presc (input sel, input run, output tick);
endinterface

// *** verilog/adcc_presc.sv ***
`timescale 1ns/100ps
module adcc_presc #(
	parameter int CNT_W = 7
) (
	// Clock and reset
	input  wire logic clk,
	input  wire logic rstn,
	// Control side
	adcc_presc_if.presc p
);
	// The largest division needs seven counter bits
	initial
	begin
		if (CNT_W < 7)
			$error("adcc_presc: CNT_W must be at least 7");
	end

	logic [CNT_W-1:0] cnt_reg;
	logic [CNT_W-1:0] cnt_next;
	logic             tick_reg;
	logic             tick_next;
	logic [CNT_W-1:0] last;

	// Terminal count; low codes below 100 divide by 2, 2, 4 and 8
	always_comb
	begin
		unique case (p.sel)
			3'h0:    last = CNT_W'(1);
			3'h1:    last = CNT_W'(1);
			3'h2:    last = CNT_W'(3);
			3'h3:    last = CNT_W'(7);
			3'h4:    last = CNT_W'(15);  // R9
			3'h5:    last = CNT_W'(31);  // R9
			3'h6:    last = CNT_W'(63);  // R9
			3'h7:    last = CNT_W'(127); // R9
		endcase
	end

	// Counter restarts while stopped so the first tick is a full period
	always_comb
	begin
		cnt_next  = cnt_reg;
		tick_next = 1'b0;
		if (!p.run)
			cnt_next = '0;
		else if (cnt_reg >= last)
		begin
			cnt_next  = '0;
			tick_next = 1'b1;
		end
		else
			cnt_next = cnt_reg + CNT_W'(1);
	end

	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			cnt_reg  <= '0;
			tick_reg <= 1'b0;
		end
		else
		begin
			cnt_reg  <= cnt_next;
			tick_reg <= tick_next;
		end
	end

	assign p.tick = tick_reg;

	// Fifteen quiet cycles of an unbroken run must end in a tick; an abort makes it vacuous
	property p_div16;
		@(posedge clk) disable iff (!rstn)
		(tick_reg && p.run && p.sel == 3'h4)
		##1 (p.run && p.sel == 3'h4 && !tick_reg)[*8]
		##1 (p.run && p.sel == 3'h4 && !tick_reg)[*7]
		|=> tick_reg;
	endproperty
	a_div16: assert property (p_div16) else $error("divide by 16 period wrong"); // R9
endmodule // adcc_presc

// *** verilog/adcc_top.sv ***
// Strobed register access was chosen for this implementation.
`timescale 1ns/100ps
module adcc_top #(
	parameter logic [4:0] CONV_CYCLES = adcc_pkg::CONV_CYCLES_DEF
) (
	// Clock and reset
	input  wire logic       clk,
	input  wire logic       rstn,
	// Register port
	input  wire logic [7:0] addr,
	input  wire logic [7:0] wdata,
	input  wire logic       wr_en,
	input  wire logic       rd_en,
	output logic      [7:0] rdata,
	// Processor state
	input  wire logic       global_int_en,
	input  wire logic       cpu_halted,
	input  wire logic       sleep_quiet_mode,
	// Analog core
	input  wire logic [9:0] sar_code,
	input  wire logic       sar_over_ref,
	output logic      [1:0] ref_source,
	output logic      [4:0] channel_gain_select,
	output logic            conv_busy,
	output logic            converter_powered,
	// Completion request
	output logic            irq
);
	initial
	begin
		if (CONV_CYCLES < 5'd2 || CONV_CYCLES > adcc_pkg::LONG_CONV_CYCLES)
			$error("adcc_top: CONV_CYCLES out of range");
	end

	adcc_presc_if pif ();
	adcc_presc u_presc (.clk(clk), .rstn(rstn), .p(pif.presc));

	adcc_pkg::adcc_state_e state_reg, state_next;
	logic [7:0] sel_reg, sel_next;
	logic [7:0] ctrl_reg, ctrl_next;
	logic       extref_reg, extref_next;
	logic [9:0] res_reg, res_next;
	logic       lock_reg, lock_next;
	logic [4:0] cnt_reg, cnt_next;
	logic       long_reg, long_next;
	logic [2:0] last_ref_reg, last_ref_next;
	logic [1:0] ref_reg, ref_next;
	logic [4:0] chan_reg, chan_next;
	logic       halt_q_reg;
	logic [7:0] rdata_reg, rdata_next;
	logic       irq_reg, irq_next;
	logic [1:0] ref_dec;
	logic [2:0] ref_bits;
	logic [9:0] res_fmt_hi;
	logic [9:0] res_fmt_lo;
	logic       done;
	logic       start;
	logic       sleep_start;
	logic       flag_new;

	// Reference decode from the select bits and the external enable
	always_comb
	begin
		if (!sel_reg[adcc_pkg::SEL_REF_LO])
			ref_dec = extref_reg ? adcc_pkg::ADCC_REF_EXTPIN : adcc_pkg::ADCC_REF_SUPPLY; // R4
		else if (!extref_reg)
			ref_dec = sel_reg[adcc_pkg::SEL_REF_HI] ? adcc_pkg::ADCC_REF_INT_2V56
				: adcc_pkg::ADCC_REF_INT_1V1; // R4
		else
			ref_dec = adcc_pkg::ADCC_REF_EXTPIN; // Undefined 011/111 kept on the pin
	end

	// Any change of the select bits or the enable counts, even one keeping the same source
	assign ref_bits = {sel_reg[adcc_pkg::SEL_REF_HI:adcc_pkg::SEL_REF_LO], extref_reg};

	// Alignment follows the live bit, not the one seen at conversion start
	always_comb
	begin
		if (sel_reg[adcc_pkg::SEL_LEFT])
		begin
			res_fmt_hi = {2'b00, res_reg[9:2]}; // R6 R7
			res_fmt_lo = {2'b00, res_reg[1:0], 6'h00};
		end
		else
		begin
			res_fmt_hi = {8'h00, res_reg[9:8]}; // R7
			res_fmt_lo = {2'b00, res_reg[7:0]};
		end
	end

	assign done = state_reg == adcc_pkg::ADCC_CONV && pif.tick
		&& cnt_reg == (long_reg ? adcc_pkg::LONG_CONV_CYCLES : CONV_CYCLES) - 5'd1;
	// Quiet-sleep trigger only when armed; other sleeps leave the converter alone
	assign sleep_start = cpu_halted && !halt_q_reg && sleep_quiet_mode // R12 R14
		&& ctrl_reg[adcc_pkg::CTRL_EN] && state_reg == adcc_pkg::ADCC_IDLE
		&& !ctrl_reg[adcc_pkg::CTRL_FREE] && ctrl_reg[adcc_pkg::CTRL_IE];

	// Register port, conversion sequencing and result capture
	always_comb
	begin
		state_next    = state_reg;
		sel_next      = sel_reg;
		ctrl_next     = ctrl_reg;
		extref_next   = extref_reg;
		res_next      = res_reg;
		lock_next     = lock_reg;
		cnt_next      = cnt_reg;
		long_next     = long_reg;
		last_ref_next = last_ref_reg;
		ref_next      = ref_reg;
		chan_next     = chan_reg;
		rdata_next    = 8'h00;
		start         = sleep_start;
		flag_new      = 1'b0;
		if (wr_en)
		begin
			unique case (addr)
				adcc_pkg::ADDR_SEL:  sel_next = wdata; // R1 R2 held until completion
				adcc_pkg::ADDR_MISC: extref_next = wdata[adcc_pkg::MISC_EXTREF];
				adcc_pkg::ADDR_CTRL:
				begin
					ctrl_next[adcc_pkg::CTRL_EN]   = wdata[adcc_pkg::CTRL_EN]; // R14
					ctrl_next[adcc_pkg::CTRL_FREE] = wdata[adcc_pkg::CTRL_FREE];
					ctrl_next[adcc_pkg::CTRL_IE]   = wdata[adcc_pkg::CTRL_IE];
					ctrl_next[2:0]                 = wdata[2:0];
					if (wdata[adcc_pkg::CTRL_DONE])
						ctrl_next[adcc_pkg::CTRL_DONE] = 1'b0; // Write one to clear
					if (wdata[adcc_pkg::CTRL_START] && wdata[adcc_pkg::CTRL_EN]
						&& state_reg == adcc_pkg::ADCC_IDLE)
						start = 1'b1;
				end
				default: ;
			endcase
		end
		if (rd_en)
		begin
			unique case (addr)
				adcc_pkg::ADDR_RES_LOW:
				begin
					rdata_next = res_fmt_lo[7:0];
					lock_next  = 1'b1; // R8
				end
				adcc_pkg::ADDR_RES_HIGH:
				begin
					rdata_next = res_fmt_hi[7:0];
					lock_next  = 1'b0; // R8
				end
				adcc_pkg::ADDR_SEL:  rdata_next = sel_reg;
				adcc_pkg::ADDR_MISC: rdata_next = {7'h00, extref_reg};
				adcc_pkg::ADDR_CTRL:
				begin
					rdata_next = ctrl_reg;
					rdata_next[adcc_pkg::CTRL_START] = state_reg == adcc_pkg::ADCC_CONV;
				end
				default: rdata_next = 8'h00;
			endcase
		end
		// Completion runs to the end whether or not the processor woke early
		if (done)
		begin
			flag_new = 1'b1; // R13 R17
			if (!lock_next) // A low-byte read in this very cycle freezes too
				res_next = sar_over_ref ? adcc_pkg::FULL_SCALE : sar_code; // R15 R18
			state_next = adcc_pkg::ADCC_IDLE;
			if (ctrl_reg[adcc_pkg::CTRL_FREE] && ctrl_next[adcc_pkg::CTRL_EN])
				start = 1'b1; // R11
		end
		else if (state_reg == adcc_pkg::ADCC_CONV && pif.tick)
			cnt_next = cnt_reg + 5'd1;
		if (start)
		begin
			// Channel and reference are latched at start, so later writes wait
			state_next    = adcc_pkg::ADCC_CONV;
			cnt_next      = 5'd0;
			chan_next     = sel_next[4:0]; // R5 R10 R11
			ref_next      = ref_dec; // R2
			long_next     = ref_bits != last_ref_reg; // R3
			last_ref_next = ref_bits;
		end
		else if (state_next == adcc_pkg::ADCC_IDLE)
		begin
			chan_next = sel_reg[4:0]; // R1 R5
			ref_next  = ref_dec; // R2
		end
		if (!ctrl_next[adcc_pkg::CTRL_EN])
			state_next = adcc_pkg::ADCC_IDLE; // Clearing enable aborts
		if (flag_new)
			ctrl_next[adcc_pkg::CTRL_DONE] = 1'b1; // Set wins over clear
		ctrl_next[adcc_pkg::CTRL_START] = 1'b0;
		irq_next = ctrl_reg[adcc_pkg::CTRL_DONE] && ctrl_reg[adcc_pkg::CTRL_IE]
			&& global_int_en; // R17
	end

	assign pif.sel = ctrl_reg[2:0];
	assign pif.run = state_reg == adcc_pkg::ADCC_CONV;

	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			state_reg    <= adcc_pkg::ADCC_IDLE;
			sel_reg      <= adcc_pkg::SEL_RST;
			ctrl_reg     <= adcc_pkg::CTRL_RST;
			extref_reg   <= 1'b0;
			res_reg      <= 10'h000;
			lock_reg     <= 1'b0;
			cnt_reg      <= 5'd0;
			long_reg     <= 1'b0;
			last_ref_reg <= 3'h0;
			ref_reg      <= adcc_pkg::ADCC_REF_SUPPLY;
			chan_reg     <= 5'h00;
			halt_q_reg   <= 1'b0;
			rdata_reg    <= 8'h00;
			irq_reg      <= 1'b0;
		end
		else
		begin
			state_reg    <= state_next;
			sel_reg      <= sel_next;
			ctrl_reg     <= ctrl_next;
			extref_reg   <= extref_next;
			res_reg      <= res_next;
			lock_reg     <= lock_next;
			cnt_reg      <= cnt_next;
			long_reg     <= long_next;
			last_ref_reg <= last_ref_next;
			ref_reg      <= ref_next;
			chan_reg     <= chan_next;
			halt_q_reg   <= cpu_halted;
			rdata_reg    <= rdata_next;
			irq_reg      <= irq_next;
		end
	end

	assign rdata               = rdata_reg;
	assign ref_source          = ref_reg;
	assign channel_gain_select = chan_reg;
	assign conv_busy           = state_reg == adcc_pkg::ADCC_CONV;
	assign converter_powered   = ctrl_reg[adcc_pkg::CTRL_EN];
	assign irq                 = irq_reg;

	property p_chan_hold;
		@(posedge clk) disable iff (!rstn)
		(state_reg == adcc_pkg::ADCC_CONV && !done && ctrl_reg[adcc_pkg::CTRL_EN])
		|=> $stable(chan_reg);
	endproperty
	a_chan_hold: assert property (p_chan_hold) else $error("channel moved mid-conversion"); // R1

	property p_ref_hold;
		@(posedge clk) disable iff (!rstn)
		(state_reg == adcc_pkg::ADCC_CONV && !done && ctrl_reg[adcc_pkg::CTRL_EN])
		|=> $stable(ref_reg);
	endproperty
	a_ref_hold: assert property (p_ref_hold) else $error("reference moved mid-conversion"); // R2

	property p_long;
		@(posedge clk) disable iff (!rstn)
		(done && long_reg) |-> cnt_reg == 5'd24;
	endproperty
	a_long: assert property (p_long) else $error("long conversion not 25 cycles"); // R3

	property p_left;
		@(posedge clk) disable iff (!rstn)
		(rd_en && addr == adcc_pkg::ADDR_RES_HIGH && sel_reg[adcc_pkg::SEL_LEFT])
		|=> rdata == $past(res_reg[9:2]);
	endproperty
	a_left: assert property (p_left) else $error("left aligned high byte wrong"); // R6

	property p_right_lo;
		@(posedge clk) disable iff (!rstn)
		(rd_en && addr == adcc_pkg::ADDR_RES_LOW && !sel_reg[adcc_pkg::SEL_LEFT])
		|=> rdata == $past(res_reg[7:0]);
	endproperty
	a_right_lo: assert property (p_right_lo) else $error("right aligned low byte wrong"); // R7

	property p_freeze;
		@(posedge clk) disable iff (!rstn)
		(rd_en && addr == adcc_pkg::ADDR_RES_LOW) ##1 (!(rd_en && addr == adcc_pkg::ADDR_RES_HIGH))[*3]
		|-> $stable(res_reg);
	endproperty
	a_freeze: assert property (p_freeze) else $error("result changed while frozen"); // R8 R18

	property p_sleep;
		@(posedge clk) disable iff (!rstn)
		sleep_start |=> conv_busy ##1 conv_busy;
	endproperty
	a_sleep: assert property (p_sleep) else $error("sleep did not start conversion"); // R12

	property p_irq;
		@(posedge clk) disable iff (!rstn)
		irq_reg == $past(ctrl_reg[adcc_pkg::CTRL_DONE] && ctrl_reg[adcc_pkg::CTRL_IE]
			&& global_int_en);
	endproperty
	a_irq: assert property (p_irq) else $error("interrupt request gating wrong"); // R17

	property p_done_flag;
		@(posedge clk) disable iff (!rstn)
		done |=> ctrl_reg[adcc_pkg::CTRL_DONE];
	endproperty
	a_done_flag: assert property (p_done_flag) else $error("done flag not set"); // R13 R17

	property p_full;
		@(posedge clk) disable iff (!rstn)
		(done && sar_over_ref && !lock_next) |=> res_reg == adcc_pkg::FULL_SCALE;
	endproperty
	a_full: assert property (p_full) else $error("over-range not full scale"); // R15

	property p_free;
		@(posedge clk) disable iff (!rstn)
		(done && ctrl_reg[adcc_pkg::CTRL_FREE] && ctrl_reg[adcc_pkg::CTRL_EN] && !wr_en)
		|=> conv_busy && cnt_reg == 5'd0;
	endproperty
	a_free: assert property (p_free) else $error("free run did not restart"); // R11

	c_single: cover property (@(posedge clk) disable iff (!rstn) done && !ctrl_reg[adcc_pkg::CTRL_FREE]);
	c_long:   cover property (@(posedge clk) disable iff (!rstn) done && long_reg);
	c_drop:   cover property (@(posedge clk) disable iff (!rstn) done && lock_reg);
	c_sleep:  cover property (@(posedge clk) disable iff (!rstn) sleep_start);
endmodule // adcc_top

// *** tb/adcc_top_bench.sv ***
`timescale 1ns/100ps
module adcc_top_bench;
	localparam logic [4:0] CONV = 5'd4;
	logic       clk;
	logic       rstn;
	logic [7:0] addr;
	logic [7:0] wdata;
	logic       wr_en;
	logic       rd_en;
	logic [7:0] rdata;
	logic       global_int_en;
	logic       cpu_halted;
	logic       sleep_quiet_mode;
	logic [9:0] sar_code;
	logic       sar_over_ref;
	logic [1:0] ref_source;
	logic [4:0] channel_gain_select;
	logic       conv_busy;
	logic       converter_powered;
	logic       irq;
	int         errors;
	int         total_checks;
	int         cycles;

	adcc_top #(.CONV_CYCLES(CONV)) i_adcc_top (
		.clk(clk), .rstn(rstn), .addr(addr), .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en),
		.rdata(rdata), .global_int_en(global_int_en), .cpu_halted(cpu_halted),
		.sleep_quiet_mode(sleep_quiet_mode), .sar_code(sar_code), .sar_over_ref(sar_over_ref),
		.ref_source(ref_source), .channel_gain_select(channel_gain_select),
		.conv_busy(conv_busy), .converter_powered(converter_powered), .irq(irq)
	);

	// Free-running clock, 10 ns period
	initial
	begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	task automatic print_verdict;
		$display("errors %0d, checks %0d", errors, total_checks);
		if (errors == 0 && total_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	// Hang guard: the longest run needs a few thousand cycles
	always @(posedge clk)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			errors++;
			print_verdict;
		end
	end

	task automatic chk(input logic [9:0] got, input logic [9:0] exp);
		total_checks++;
		if (got !== exp)
		begin
			errors++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// Register bus master: strobes last one cycle, change just after the edge
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr_en <= 1'b1;
		@(posedge clk);
		wr_en <= 1'b0;
	endtask

	// Read data stand only in the cycle after the strobe
	task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
		@(posedge clk);
		addr <= a;
		rd_en <= 1'b1;
		@(posedge clk);
		rd_en <= 1'b0;
		#1 chk(rdata, exp);
	endtask

	// Bounded wait for the end of a conversion, returns cycles spent busy
	task automatic wait_done(output int n);
		n = 0;
		do
		begin
			@(posedge clk);
			#1 n++;
		end
		while (conv_busy !== 1'b0 && n < 5000);
		if (conv_busy !== 1'b0)
		begin
			errors++;
			$display("wrong value at %0t: conversion never ended", $time);
		end
	endtask

	task automatic chk_len(input int n, input int exp);
		chk(10'(n >= exp - 2 && n <= exp + 2), 10'h001);
	endtask

	task automatic t_reset;
		wr(8'h78, 8'h55);
		rdc(8'h78, 8'h00);
		rdc(8'h79, 8'h00);
		rdc(8'h7c, 8'h00);
		rdc(8'h50, 8'h00);
	endtask

	// Each prescale code stretches the conversion by its divider
	task automatic t_presc;
		int n;
		for (int c = 0; c < 8; c++)
		begin
			wr(8'h7a, 8'h80 | 8'h40 | 8'(c));
			wait_done(n);
			chk_len(n, int'(CONV) * (2 << ((c > 0) ? c - 1 : 0)));
		end
		wr(8'h7a, 8'h94);
	endtask

	task automatic convert;
		int n;
		wr(8'h7a, 8'hd4);
		wait_done(n);
	endtask

	task automatic t_align;
		sar_code <= 10'h2a5;
		convert;
		rdc(8'h78, 8'ha5);
		rdc(8'h79, 8'h02);
		wr(8'h7c, 8'h20);
		rdc(8'h78, 8'h40);
		rdc(8'h79, 8'ha9);
		@(posedge clk);
		sar_over_ref <= 1'b1;
		convert;
		rdc(8'h78, 8'hc0);
		rdc(8'h79, 8'hff);
		@(posedge clk);
		sar_over_ref <= 1'b0;
		wr(8'h7c, 8'h00);
	endtask

	// A completion between the two byte reads must not reach the result
	task automatic t_freeze;
		sar_code <= 10'h2a5;
		convert;
		rdc(8'h78, 8'ha5);
		@(posedge clk);
		sar_code <= 10'h15a;
		convert;
		rdc(8'h79, 8'h02);
		rdc(8'h78, 8'ha5);
		rdc(8'h79, 8'h02);
	endtask

	task automatic t_defer;
		int n;
		wr(8'h7c, 8'h03);
		wr(8'h7a, 8'hd4);
		repeat (16) @(posedge clk);
		wr(8'h7c, 8'h45);
		repeat (4) @(posedge clk);
		#1 chk(channel_gain_select, 10'h003);
		chk(ref_source, 10'h000);
		wait_done(n);
		repeat (2) @(posedge clk);
		#1 chk(channel_gain_select, 10'h005);
		chk(ref_source, 10'h002);
	endtask

	// Every source in turn, each one different from the one before
	// The first result after each switch is left unread
	task automatic t_reference_select;
		logic [1:0] sel [4] = '{2'b10, 2'b01, 2'b11, 2'b00};
		logic       ext [4] = '{1'b1, 1'b0, 1'b0, 1'b0};
		logic [1:0] exp [4] = '{2'b01, 2'b10, 2'b11, 2'b00};
		int n;
		for (int i = 0; i < 4; i++)
		begin
			wr(8'h7c, {sel[i], 6'h00});
			wr(8'h7b, {7'h00, ext[i]});
			wr(8'h7a, 8'hd4);
			@(posedge clk);
			#1 chk(ref_source, exp[i]);
			wait_done(n);
			chk_len(n + 1, 25 * 16);
		end
	endtask

	// A channel change after the first completion lands one conversion late
	task automatic t_free;
		wr(8'h7c, 8'h01);
		wr(8'h7a, 8'he4);
		repeat (70) @(posedge clk);
		wr(8'h7c, 8'h02);
		repeat (20) @(posedge clk);
		#1 chk(channel_gain_select, 10'h001);
		repeat (50) @(posedge clk);
		#1 chk(channel_gain_select, 10'h002);
		wr(8'h7a, 8'h10);
	endtask

	task automatic t_irq_sleep;
		int n;
		wr(8'h7a, 8'hcc);
		wait_done(n);
		rdc(8'h7a, 8'h9c);
		repeat (2) @(posedge clk);
		#1 chk(irq, 10'h000);
		@(posedge clk);
		global_int_en <= 1'b1;
		repeat (2) @(posedge clk);
		#1 chk(irq, 10'h001);
		wr(8'h7a, 8'h9c);
		repeat (2) @(posedge clk);
		#1 chk(irq, 10'h000);
		@(posedge clk);
		sleep_quiet_mode <= 1'b1;
		cpu_halted <= 1'b1;
		repeat (2) @(posedge clk);
		#1 chk(conv_busy, 10'h001);
		@(posedge clk);
		cpu_halted <= 1'b0;
		wait_done(n);
		repeat (2) @(posedge clk);
		#1 chk(irq, 10'h001);
		wr(8'h7a, 8'h9c);
		sleep_quiet_mode <= 1'b0;
		cpu_halted <= 1'b1;
		repeat (5) @(posedge clk);
		#1 chk(conv_busy, 10'h000);
		chk(converter_powered, 10'h001);
	endtask

	// Main sequence: reset held for 20 cycles, then each scenario
	initial
	begin
		errors = 0;
		total_checks = 0;
		cycles = 0;
		rstn = 1'b0;
		addr = 8'h00;
		wdata = 8'h00;
		wr_en = 1'b0;
		rd_en = 1'b0;
		global_int_en = 1'b0;
		cpu_halted = 1'b0;
		sleep_quiet_mode = 1'b0;
		sar_code = 10'h000;
		sar_over_ref = 1'b0;
		repeat (20) @(posedge clk);
		rstn <= 1'b1;
		t_reset;
		t_presc;
		t_align;
		t_freeze;
		t_defer;
		t_reference_select;
		t_free;
		t_irq_sleep;
		print_verdict;
	end
endmodule // adcc_top_bench
